// *** fault_report_and_sense_cal.sv ***
// Top of the fault report and sense calibration block: APB registers,
// latched faults with clear-on-read, sense amp settings, fault pin.
// Assumes APB master on pclk; frame strobe and fault detectors are
// asynchronous; frame edge count and parity come from the serial
// framer on pclk and hold until the next frame.
`timescale 1ns/1ps
// Contract
// RL1 - Gain code 0..6 gives 10..40, 7 gives 50
// RL2 - Offset code maps to 0 mV up to 2.5 V
// RL3 - Calibrate only on trigger written 0 to 1
// RL4 - Controller clears offset-only, keeps inputs equal
// RL5 - Start at strobe rise, end within cal time
// RL6 - Offset-only select picks offset or signal
// RL7 - Status bit 15 shows any latched fault
// RL8 - Fault flag readable once strobe goes low
// RL9 - Faults latch, clear on read unless suppressed; F_EE bit 3 never clears on read
// RL10 - Non-critical faults are maskable, then ignored
// RL11 - Separate chip, monitor and bridge fault bits
// RL12 - Pin select: general, pulsed, general, clock
// RL13 - General mode: low while fault or disabled
// RL14 - Pulsed mode: 100 ms period, 20/80% duty
// RL15 - Fault pin is open drain only
// RL16 - Bad frame cancels transfer, sets serial error
// RL17 - Clock mode divides internal clock by fixed ratio
module fault_report_and_sense_cal
  import fr_pkg::*;
#(
  parameter int PERIOD_CYCLES = PULSE_PERIOD_CYC,
  parameter int CAL_CYCLES = CAL_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic frame_strobe_n,
  input wire logic [4:0] frame_edge_cnt,
  input wire logic frame_parity_odd,
  input wire logic nvm_save_busy,
  input wire logic [20:0] fault_raw,
  input wire logic outputs_fault_off,
  output logic [5:0] amp_gain,
  output logic [11:0] output_offset_mv,
  output logic offset_only_select,
  output logic cal_active,
  output logic any_fault_serial_bit,
  output logic fault_pin_o,
  output logic fault_pin_oe,
  output logic irq
);
  logic [CTRL_W-1:0] ctrl_r;
  logic [NFAULT-1:0] fault_r;
  logic [NFAULT-1:0] fault_nxt;
  logic [NFAULT-1:0] mask_r;
  logic [NIRQ-1:0] ists_r;
  logic [NIRQ-1:0] imsk_r;
  logic [NIRQ-1:0] ists_nxt;
  logic [NFAULT-1:0] raw_m_r;
  logic [NFAULT-1:0] raw_s_r;
  logic [1:0] stb_sync_r;
  logic stb_d_r;
  logic strobe_rise;
  logic frame_ok;
  logic setup_ph;
  logic acc_ph;
  logic wr_done;
  logic rd_done;
  logic cal_arm;
  logic cal_run;
  logic cal_done;
  logic cal_cancel;
  logic pull_low;
  logic fault_present;
  logic [NFAULT-1:0] fault_set;
  logic [NFAULT-1:0] rd_clr;
  logic [31:0] rd_mux;
  logic addr_ok;

  // Synchronisers for frame strobe and raw fault detectors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stb_sync_r <= 2'h3;
      stb_d_r <= 1'b1;
      raw_m_r <= '0;
      raw_s_r <= '0;
    end else begin
      stb_sync_r <= {stb_sync_r[0], frame_strobe_n};
      stb_d_r <= stb_sync_r[1];
      raw_m_r <= fault_raw;
      raw_s_r <= raw_m_r;
    end
  end

  assign strobe_rise = stb_sync_r[1] && !stb_d_r;
  // RL16 frame validity check
  assign frame_ok = (frame_edge_cnt == FRAME_EDGES) && frame_parity_odd && !nvm_save_busy;

  // APB phase decode
  assign setup_ph = psel && !penable;
  assign acc_ph = psel && penable && pready;
  assign wr_done = acc_ph && pwrite;
  assign rd_done = acc_ph && !pwrite;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == CTRL_OFF) || (a == STAT_OFF) || (a == FAULT_PIN_OFF) ||
                (a == MASK_OFF) || (a == ISTS_OFF) || (a == IMSK_OFF);
  endfunction : is_mapped

  assign addr_ok = is_mapped(paddr);

  // Read data mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      CTRL_OFF: rd_mux[CTRL_W-1:0] = ctrl_r;
      // RL7 common flag in status bit 15
      STAT_OFF: rd_mux = {16'h0000, |fault_r, 4'h0, fault_r[NSTAT-1:0]};
      FAULT_PIN_OFF: rd_mux[NDIAG-1:0] = fault_r[NFAULT-1:NSTAT];
      MASK_OFF: rd_mux[NFAULT-1:0] = mask_r;
      ISTS_OFF: rd_mux[NIRQ-1:0] = ists_r;
      IMSK_OFF: rd_mux[NIRQ-1:0] = imsk_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // APB answer: one wait-free access phase, data captured in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      if (setup_ph) prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= setup_ph && !addr_ok;
    end
  end

  // RL3 arm only on a 0 to 1 write of the trigger
  assign cal_arm = wr_done && (paddr == CTRL_OFF) && pwdata[CAL_BIT] && !ctrl_r[CAL_BIT];

  // Control, mask and interrupt mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      mask_r <= '0;
      imsk_r <= '0;
    end else if (wr_done) begin
      if (paddr == CTRL_OFF) ctrl_r <= pwdata[CTRL_W-1:0];
      // RL10 chip-level faults cannot be masked
      if (paddr == MASK_OFF) mask_r <= pwdata[NFAULT-1:0] & MASKABLE;
      if (paddr == IMSK_OFF) imsk_r <= pwdata[NIRQ-1:0];
    end
  end

  // RL10 masked faults neither latch nor drive the pin
  assign fault_set = (raw_s_r & ~mask_r) | (NFAULT'(cal_cancel) << F_SE);

  // RL9 clear-on-read per register, suppressed by the DSR-style bit
  always_comb begin
    rd_clr = '0;
    if (rd_done && !ctrl_r[DSR_BIT]) begin
      if (paddr == STAT_OFF) rd_clr[NSTAT-1:0] = prdata[NSTAT-1:0];
      if (paddr == FAULT_PIN_OFF) rd_clr[NFAULT-1:NSTAT] = prdata[NDIAG-1:0];
    end
    rd_clr = rd_clr & RDCLR_OK;
  end

  // RL11 one latched bit per detector, set wins over clear
  assign fault_nxt = (fault_r & ~rd_clr) | fault_set;

  // RL9 fault latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r <= FAULT_RST;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  // Interrupt status: sticky, write one to clear, events win
  assign ists_nxt = {|(fault_set & ~fault_r), cal_cancel, cal_done};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ists_r <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_done && (paddr == ISTS_OFF)) begin
        ists_r <= (ists_r & ~pwdata[NIRQ-1:0]) | ists_nxt;
      end else begin
        ists_r <= ists_r | ists_nxt;
      end
      irq <= |(ists_r & imsk_r);
    end
  end

  // RL5 calibration sequencer started by the frame strobe rise
  cal_seq #(.CAL_CYCLES(CAL_CYCLES)) u_cal (
    .pclk(pclk),
    .presetn(presetn),
    .arm(cal_arm),
    .strobe_rise(strobe_rise),
    .frame_ok(frame_ok),
    .cal_active(cal_run),
    .cal_done(cal_done),
    .cal_cancel(cal_cancel)
  );

  // RL13 fault present or outputs disabled by a latched fault
  assign fault_present = |(raw_s_r & ~mask_r) || outputs_fault_off;

  // RL12 RL14 RL17 pin waveform by mode
  fault_pin_pin_gen #(.PERIOD(PERIOD_CYCLES)) u_pin (
    .pclk(pclk),
    .presetn(presetn),
    .pin_mode(ctrl_r[PSEL_LSB+1:PSEL_LSB]),
    .fault_active(fault_present),
    .pull_low(pull_low)
  );

  // Amplifier settings and serial fault bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_gain <= gain_of(3'h0);
      output_offset_mv <= offset_mv(4'h0);
      offset_only_select <= 1'b0;
      cal_active <= 1'b0;
      any_fault_serial_bit <= 1'b0;
    end else begin
      // RL1 gain decode
      amp_gain <= gain_of(ctrl_r[GAIN_LSB+2:GAIN_LSB]);
      // RL2 offset decode
      output_offset_mv <= offset_mv(ctrl_r[OFFS_LSB+3:OFFS_LSB]);
      // RL6 offset-only select
      offset_only_select <= ctrl_r[OSO_BIT];
      cal_active <= cal_run;
      // RL8 first serial bit while strobe is low
      any_fault_serial_bit <= !stb_sync_r[1] && (|fault_r);
    end
  end

  // RL15 open drain: only pull low or release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_pin_o <= 1'b0;
      fault_pin_oe <= 1'b0;
    end else begin
      fault_pin_o <= 1'b0;
      fault_pin_oe <= pull_low;
    end
  end

  // Helper: length of a calibration run
  int cal_len_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_len_r <= 0;
    end else begin
      cal_len_r <= cal_active ? cal_len_r + 1 : 0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ctrl_write_s;
    wr_done && (paddr == CTRL_OFF);
  endsequence

  gain_map_a: assert property ( // RL1
    ctrl_write_s and (pwdata[GAIN_LSB+2:GAIN_LSB] == 3'h7) |-> ##2 amp_gain == 6'h32)
    else $error("gain code 7 did not give 50");

  offset_map_a: assert property ( // RL2
    ctrl_write_s and (pwdata[OFFS_LSB+3:OFFS_LSB] == 4'hC) |-> ##2 output_offset_mv == 12'h672)
    else $error("offset code 12 did not give 1650 mV");

  cal_rearm_a: assert property ( // RL3
    ctrl_write_s and ctrl_r[CAL_BIT] |-> !cal_arm)
    else $error("calibration armed while trigger already set");

  cal_start_a: assert property ( // RL5
    $rose(cal_run) |-> $past(strobe_rise) && $past(frame_ok))
    else $error("calibration started without a valid strobe rise");

  cal_len_a: assert property ( // RL5
    cal_len_r <= CAL_CYCLES)
    else $error("calibration ran past its time");

  ff_bit_a: assert property ( // RL7
    setup_ph && !pwrite && (paddr == STAT_OFF) |=> prdata[FF_BIT] == $past(|fault_r))
    else $error("status bit 15 does not match latched faults");

  ff_serial_a: assert property ( // RL8
    !stb_sync_r[1] && (|fault_r) |=> any_fault_serial_bit)
    else $error("fault flag missing while strobe low");

  dsr_hold_a: assert property ( // RL9
    rd_done && ctrl_r[DSR_BIT] |=> (fault_r & $past(fault_r)) == $past(fault_r))
    else $error("fault bit cleared under clear-suppress");

  se_set_a: assert property ( // RL16
    cal_cancel |=> fault_r[F_SE] && !cal_active)
    else $error("bad frame did not set serial error");

  pin_od_a: assert property ( // RL15
    fault_pin_oe |-> !fault_pin_o)
    else $error("fault pin driven high");

  sequence stat_read_s;
    rd_done && (paddr == STAT_OFF);
  endsequence

  apb_ready_a: assert property (
    setup_ph |=> pready && (pslverr == !$past(addr_ok)))
    else $error("access phase not answered at once");

  oso_follow_a: assert property ( // RL6
    ctrl_write_s |-> ##2 offset_only_select == $past(pwdata[OSO_BIT], 2))
    else $error("offset-only output does not follow its bit");

  mask_block_a: assert property ( // RL10
    ((fault_r & ~$past(fault_r)) & $past(mask_r)) == '0)
    else $error("masked fault was latched");

  stat_clear_a: assert property ( // RL9
    stat_read_s and !ctrl_r[DSR_BIT] |=> (fault_r[NSTAT-1:0] &
      $past(prdata[NSTAT-1:0] & ~fault_set[NSTAT-1:0]) & RDCLR_OK[NSTAT-1:0]) == '0)
    else $error("status read did not clear the read bits");

  cal_done_a: assert property ( // RL5
    $fell(cal_run) |-> cal_done)
    else $error("calibration ended without done event");

  pin_gen_a: assert property ( // RL13
    !ctrl_r[PSEL_LSB] && fault_present |-> ##2 fault_pin_oe)
    else $error("fault pin not pulled low in general mode");

  pin_free_a: assert property ( // RL13
    !ctrl_r[PSEL_LSB] && !fault_present |-> ##2 !fault_pin_oe)
    else $error("fault pin held low with no fault");

  irq_level_a: assert property (
    |(ists_r & imsk_r) |=> irq)
    else $error("interrupt missing for unmasked status");
endmodule : fault_report_and_sense_cal

// *** fr_pkg.sv ***
// Shared constants, register map and decode functions for the
// fault report and sense calibration block.
// Assumes one 125 MHz clock and an APB master in that domain.
package fr_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] FAULT_PIN_OFF = 8'h08;
  localparam logic [7:0] MASK_OFF = 8'h0C;
  localparam logic [7:0] ISTS_OFF = 8'h10;
  localparam logic [7:0] IMSK_OFF = 8'h14;
  // Control register fields
  localparam int GAIN_LSB = 0;
  localparam int OFFS_LSB = 3;
  localparam int OSO_BIT = 7;
  localparam int CAL_BIT = 8;
  localparam int PSEL_LSB = 9;
  localparam int DSR_BIT = 11;
  localparam int CTRL_W = 12;
  localparam logic [11:0] CTRL_RST = 12'h000;
  // Fault vector: chip, monitor, bridge groups
  localparam int NFAULT = 21;
  localparam int NSTAT = 11;
  localparam int NDIAG = 10;
  localparam int F_POR = 0;
  localparam int F_SE = 2;
  localparam int F_EE = 3;
  localparam int FF_BIT = 15;
  localparam logic [20:0] FAULT_RST = 21'h000001;
  localparam logic [20:0] MASKABLE = 21'h1FFFF0;
  localparam logic [20:0] RDCLR_OK = 21'h1FFFF7;
  // Interrupt status bits
  localparam int NIRQ = 3;
  localparam int IRQ_CAL = 0;
  localparam int IRQ_SE = 1;
  localparam int IRQ_FLT = 2;
  // Fault pin modes
  localparam logic [1:0] FP_GEN0 = 2'h0;
  localparam logic [1:0] FP_PULSE = 2'h1;
  localparam logic [1:0] FP_GEN2 = 2'h2;
  localparam logic [1:0] FP_CLOCK = 2'h3;
  // Timing
  localparam int CLK_KHZ = 125000;
  localparam int PULSE_PERIOD_MS = 100;
  localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_MS * CLK_KHZ;
  localparam int DUTY_FAULT_PCT = 20;
  localparam int DUTY_OK_PCT = 80;
  localparam int CAL_TIME_US = 100;
  localparam int CAL_CYC = CAL_TIME_US * (CLK_KHZ / 1000);
  localparam int CLKDIV_HALF = 4;
  localparam logic [4:0] FRAME_EDGES = 5'h10;

  typedef enum logic [1:0] {CAL_IDLE, CAL_ARMED, CAL_RUN} cal_state_t;

  // Gain code to amplifier gain
  function automatic logic [5:0] gain_of(input logic [2:0] c);
    gain_of = (c == 3'h7) ? 6'h32 : 6'(6'h0A + 6'(c) * 6'h05);
  endfunction : gain_of

  // Offset code to output offset in millivolts
  function automatic logic [11:0] offset_mv(input logic [3:0] c);
    case (c)
      4'h0, 4'h1: offset_mv = 12'h000;
      4'h2, 4'h3: offset_mv = 12'h064;
      4'h4: offset_mv = 12'h0C8;
      4'h5: offset_mv = 12'h12C;
      4'h6: offset_mv = 12'h190;
      4'h7: offset_mv = 12'h1F4;
      4'h8: offset_mv = 12'h2EE;
      4'h9: offset_mv = 12'h3E8;
      4'hA: offset_mv = 12'h4E2;
      4'hB: offset_mv = 12'h5DC;
      4'hC: offset_mv = 12'h672;
      4'hD: offset_mv = 12'h7D0;
      4'hE: offset_mv = 12'h8CA;
      default: offset_mv = 12'h9C4;
    endcase
  endfunction : offset_mv
endpackage : fr_pkg

// *** cal_seq.sv ***
// Offset calibration sequencer: arm, start on frame strobe rise, run.
// Assumes strobe_rise is already synchronised to pclk.
`timescale 1ns/1ps
module cal_seq
  import fr_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic arm,
  input wire logic strobe_rise,
  input wire logic frame_ok,
  output logic cal_active,
  output logic cal_done,
  output logic cal_cancel
);
  localparam int CW = $clog2(CAL_CYCLES + 1);
  cal_state_t state_r;
  logic [CW-1:0] cnt_r;

  // Sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= CAL_IDLE;
    end else begin
      case (state_r)
        CAL_IDLE: if (arm) state_r <= CAL_ARMED;
        CAL_ARMED: if (strobe_rise) state_r <= frame_ok ? CAL_RUN : CAL_IDLE;
        CAL_RUN: if (cnt_r == CW'(CAL_CYCLES - 1)) state_r <= CAL_IDLE;
        default: state_r <= CAL_IDLE;
      endcase
    end
  end

  // Run length counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= (state_r == CAL_RUN) ? CW'(cnt_r + 1'b1) : '0;
    end
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_done <= 1'b0;
      cal_cancel <= 1'b0;
    end else begin
      cal_done <= (state_r == CAL_RUN) && (cnt_r == CW'(CAL_CYCLES - 1));
      cal_cancel <= (state_r == CAL_ARMED) && strobe_rise && !frame_ok;
    end
  end

  assign cal_active = (state_r == CAL_RUN);
endmodule : cal_seq

// *** fault_pin_pin_gen.sv ***
// Fault pin waveform: general flag, pulsed flag or divided clock.
// Assumes fault_active is a pclk-domain level.
`timescale 1ns/1ps
module fault_pin_pin_gen
  import fr_pkg::*;
#(
  parameter int PERIOD = PULSE_PERIOD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] pin_mode,
  input wire logic fault_active,
  output logic pull_low
);
  localparam int CW = $clog2(PERIOD + 1);
  localparam int HI_FLT = PERIOD / 100 * DUTY_FAULT_PCT;
  localparam int HI_OK = PERIOD / 100 * DUTY_OK_PCT;
  logic [CW-1:0] per_r;
  logic [2:0] div_r;
  logic clk_lvl_r;
  logic hi_now;

  // Pulse period counter and fixed clock divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_r <= '0;
      div_r <= 3'h0;
      clk_lvl_r <= 1'b1;
    end else begin
      per_r <= (per_r == CW'(PERIOD - 1)) ? '0 : CW'(per_r + 1'b1);
      div_r <= (div_r == 3'(CLKDIV_HALF - 1)) ? 3'h0 : 3'(div_r + 1'b1);
      if (div_r == 3'(CLKDIV_HALF - 1)) clk_lvl_r <= !clk_lvl_r;
    end
  end

  assign hi_now = fault_active ? (per_r < CW'(HI_FLT)) : (per_r < CW'(HI_OK));

  // Pin pull-down select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_low <= 1'b0;
    end else begin
      case (pin_mode)
        FP_PULSE: pull_low <= !hi_now;
        FP_CLOCK: pull_low <= !clk_lvl_r;
        default: pull_low <= fault_active;
      endcase
    end
  end
endmodule : fault_pin_pin_gen

// *** fr_mcu_model.sv ***
// Controller side model: frame strobe and the framer's frame results.
// Assumes the bench calls its tasks from the pclk domain.
`timescale 1ns/1ps
module fr_mcu_model (
  input wire logic pclk,
  output logic frame_strobe_n,
  output logic [4:0] frame_edge_cnt,
  output logic frame_parity_odd,
  output logic nvm_save_busy
);
  // Idle strobe high, no save running
  initial begin
    frame_strobe_n = 1'b1;
    frame_edge_cnt = 5'h00;
    frame_parity_odd = 1'b0;
    nvm_save_busy = 1'b0;
  end

  // Strobe low just after an edge
  task automatic open_frame();
    @(posedge pclk);
    frame_strobe_n <= 1'b0;
  endtask : open_frame

  task automatic close_frame(input logic [4:0] edges, input logic par);
    @(posedge pclk);
    frame_edge_cnt <= edges;
    frame_parity_odd <= par;
    @(posedge pclk);
    frame_strobe_n <= 1'b1;
  endtask : close_frame
endmodule : fr_mcu_model

// *** fault_report_and_sense_cal_bench.sv ***
// Self-checking bench: APB register tests, faults, calibration, fault pin.
// Assumes zero-wait APB slave and shortened pulse and calibration counts.
`timescale 1ns/1ps
module fault_report_and_sense_cal_bench;
  import fr_pkg::*;
  localparam int PER_N = 100;
  localparam int CAL_N = 20;
  logic pclk;
  logic presetn;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic frame_strobe_n;
  logic [4:0] frame_edge_cnt;
  logic frame_parity_odd;
  logic nvm_save_busy;
  logic [20:0] fault_raw;
  logic outputs_fault_off;
  logic [5:0] amp_gain;
  logic [11:0] output_offset_mv;
  logic offset_only_select;
  logic cal_active;
  logic any_fault_serial_bit;
  logic fault_pin_o;
  logic fault_pin_oe;
  logic irq;
  logic drv_high;
  int bad_count;
  int compares;
  int cycles;
  logic [5:0] gains [8] = '{6'h0A, 6'h0F, 6'h14, 6'h19, 6'h1E, 6'h23, 6'h28, 6'h32};
  logic [11:0] offs [16] = '{12'h000, 12'h000, 12'h064, 12'h064, 12'h0C8, 12'h12C,
    12'h190, 12'h1F4, 12'h2EE, 12'h3E8, 12'h4E2, 12'h5DC, 12'h672, 12'h7D0, 12'h8CA,
    12'h9C4};

  fault_report_and_sense_cal #(.PERIOD_CYCLES(PER_N), .CAL_CYCLES(CAL_N))
    fault_report_and_sense_cal_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .frame_strobe_n(frame_strobe_n),
    .frame_edge_cnt(frame_edge_cnt), .frame_parity_odd(frame_parity_odd),
    .nvm_save_busy(nvm_save_busy), .fault_raw(fault_raw),
    .outputs_fault_off(outputs_fault_off), .amp_gain(amp_gain),
    .output_offset_mv(output_offset_mv), .offset_only_select(offset_only_select),
    .cal_active(cal_active), .any_fault_serial_bit(any_fault_serial_bit),
    .fault_pin_o(fault_pin_o), .fault_pin_oe(fault_pin_oe), .irq(irq));

  fr_mcu_model fr_mcu_model_inst (.pclk(pclk), .frame_strobe_n(frame_strobe_n),
    .frame_edge_cnt(frame_edge_cnt), .frame_parity_odd(frame_parity_odd),
    .nvm_save_busy(nvm_save_busy));

  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // pin output must never be high
  always @(posedge pclk) begin
    if (fault_pin_o !== 1'b0) drv_high <= 1'b1;
  end

  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string w);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
    check(q, exp, w);
  endtask : rd_chk

  // Detector pulse long enough to pass the synchroniser
  task automatic pulse_fault(input int b);
    @(posedge pclk);
    fault_raw[b] <= 1'b1;
    cyc(4);
    fault_raw[b] <= 1'b0;
    cyc(4);
  endtask : pulse_fault

  task automatic watch_cal(output int hi);
    hi = 0;
    repeat (40) begin
      @(posedge pclk);
      if (cal_active === 1'b1) hi++;
    end
  endtask : watch_cal

  task automatic count_oe(input int n, output int hi);
    hi = 0;
    repeat (n) begin
      @(posedge pclk);
      if (fault_pin_oe === 1'b1) hi++;
    end
  endtask : count_oe

  initial begin
    logic [31:0] q;
    logic e;
    int hi;
    presetn = 1'b0;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h00000000;
    fault_raw = 21'h000000;
    outputs_fault_off = 1'b0;
    drv_high = 1'b0;
    bad_count = 0;
    compares = 0;
    cycles = 0;
    cyc(8);
    presetn <= 1'b1;
    check(amp_gain, 6'h0A, "gain at reset");
    rd_chk(STAT_OFF, 32'h00008001, "status at reset");
    rd_chk(STAT_OFF, 32'h00000000, "status cleared");
    // Every gain and offset code
    for (int i = 0; i < 16; i++) begin
      wr(CTRL_OFF, {25'h0000000, 4'(i), 3'(i)});
      cyc(2);
      check(amp_gain, gains[i % 8], "gain");
      check(output_offset_mv, offs[i], "offset");
    end
    wr(CTRL_OFF, 32'h00000080);
    cyc(2);
    check(offset_only_select, 1'b1, "offset only");
    wr(CTRL_OFF, 32'h00000000);
    cyc(2);
    check(offset_only_select, 1'b0, "signal plus offset");
    apb(1'b0, 8'h40, 32'h00000000, q, e);
    check(e, 1'b1, "unmapped error");
    check(q, 32'h00000000, "unmapped data");
    $display("test settings done");
    // Latch, suppressed clear, clear on read
    pulse_fault(1);
    wr(CTRL_OFF, 32'h00000800);
    rd_chk(STAT_OFF, 32'h00008002, "suppressed read");
    rd_chk(STAT_OFF, 32'h00008002, "still latched");
    wr(CTRL_OFF, 32'h00000000);
    rd_chk(STAT_OFF, 32'h00008002, "latched");
    rd_chk(STAT_OFF, 32'h00000000, "cleared");
    pulse_fault(11);
    rd_chk(STAT_OFF, 32'h00008000, "flag from bridge group");
    rd_chk(FAULT_PIN_OFF, 32'h00000001, "overcurrent bit");
    rd_chk(STAT_OFF, 32'h00000000, "flag clears");
    // Mask register and masked fault
    wr(MASK_OFF, 32'h0000001F);
    rd_chk(MASK_OFF, 32'h00000010, "mask readback");
    pulse_fault(4);
    rd_chk(STAT_OFF, 32'h00000000, "masked fault");
    wr(MASK_OFF, 32'h00000000);
    pulse_fault(4);
    rd_chk(STAT_OFF, 32'h00008010, "unmasked fault");
    $display("test faults done");
    // Interrupt raise, mask, clear
    wr(ISTS_OFF, 32'h00000007);
    wr(IMSK_OFF, 32'h00000000);
    pulse_fault(5);
    rd_chk(ISTS_OFF, 32'h00000004, "irq status");
    check(irq, 1'b0, "irq masked");
    wr(IMSK_OFF, 32'h00000004);
    cyc(2);
    check(irq, 1'b1, "irq raised");
    wr(ISTS_OFF, 32'h00000004);
    cyc(2);
    check(irq, 1'b0, "irq cleared");
    rd_chk(STAT_OFF, 32'h00008020, "gate supply fault");
    $display("test irq done");
    // offset-only cleared and inputs idle before the trigger
    wr(CTRL_OFF, 32'h00000100);
    fr_mcu_model_inst.open_frame();
    cyc(3);
    check(any_fault_serial_bit, 1'b0, "no fault flag");
    fr_mcu_model_inst.close_frame(5'h10, 1'b1);
    watch_cal(hi);
    check(hi, CAL_N, "cal length");
    rd_chk(ISTS_OFF, 32'h00000001, "cal done");
    wr(CTRL_OFF, 32'h00000100);
    fr_mcu_model_inst.open_frame();
    fr_mcu_model_inst.close_frame(5'h10, 1'b1);
    watch_cal(hi);
    check(hi, 0, "trigger already set");
    wr(CTRL_OFF, 32'h00000000);
    wr(CTRL_OFF, 32'h00000100);
    fr_mcu_model_inst.open_frame();
    fr_mcu_model_inst.close_frame(5'h0F, 1'b1);
    watch_cal(hi);
    check(hi, 0, "short frame");
    fr_mcu_model_inst.open_frame();
    cyc(4);
    check(any_fault_serial_bit, 1'b1, "fault flag on strobe");
    fr_mcu_model_inst.close_frame(5'h10, 1'b1);
    cyc(4);
    check(any_fault_serial_bit, 1'b0, "flag off after frame");
    rd_chk(STAT_OFF, 32'h00008004, "serial error");
    // Even parity on the trigger frame cancels too
    wr(CTRL_OFF, 32'h00000000);
    wr(CTRL_OFF, 32'h00000100);
    fr_mcu_model_inst.open_frame();
    fr_mcu_model_inst.close_frame(5'h10, 1'b0);
    watch_cal(hi);
    check(hi, 0, "even parity");
    rd_chk(STAT_OFF, 32'h00008004, "serial error on parity");
    $display("test calibration done");
    // General flag modes 0 and 2
    for (int m = 0; m < 4; m += 2) begin
      wr(CTRL_OFF, {21'h000000, 2'(m), 9'h000});
      // Two sync stages, pin mux and pin flop: oe settles on the fourth edge
      fault_raw[1] <= 1'b1;
      cyc(5);
      check(fault_pin_oe, 1'b1, "pin low on fault");
      fault_raw[1] <= 1'b0;
      cyc(5);
      check(fault_pin_oe, 1'b0, "pin released");
    end
    outputs_fault_off <= 1'b1;
    cyc(4);
    check(fault_pin_oe, 1'b1, "pin low on disable");
    outputs_fault_off <= 1'b0;
    wr(CTRL_OFF, 32'h00000200);
    cyc(PER_N);
    count_oe(PER_N, hi);
    check(hi, 20, "pulse duty ok");
    fault_raw[1] <= 1'b1;
    cyc(PER_N);
    count_oe(PER_N, hi);
    check(hi, 80, "pulse duty fault");
    fault_raw[1] <= 1'b0;
    wr(CTRL_OFF, 32'h00000600);
    cyc(8);
    count_oe(80, hi);
    check(hi, 40, "clock mode");
    check(drv_high, 1'b0, "pin never high");
    $display("test fault pin done");
    wrap_up();
  end
endmodule : fault_report_and_sense_cal_bench
